//--- power_mode_controller.sv
`include "pmc_cfg.svh"

// What this block does
// R1 - normal mode runs basic blocks; software gates each peripheral clock
// R2 - idle stops core clock; bus, memory, interrupt, power logic keep running
// R3 - idle ends on any external line 23..0, alarm or other interrupt
// R4 - slow core clock is crystal divided: code 0 by 1, else by 2n
// R5 - slow bus clocks optionally halved from core and system bus clocks
// R6 - leaving slow with pll off inserts lock wait from lock count
// R7 - lock wait after pll on; core stays on slow clock meanwhile
// R8 - slow bit with pll on selects slow clock while slow lasts
// R9 - slow cleared after lock elapsed switches to pll clock at once
// R10 - slow and pll-off cleared together switch only after lock time
// R11 - sleep removes core power; wakes only on lines 15..0 or alarm
// R12 - software sets sleep bit as its last step before sleeping
// R13 - software masks interrupts, suspends pads, self-refreshes memory first
// R14 - wake raises internal reset for 65535 crystal periods via 16-bit counter
// R15 - reset status bit 2 tells a wake from sleep
// R16 - scratch bits 4:3 survive sleep
// R17 - wake sets pending: lines 3..0 source, 15..4 external, battery source
// R18 - masked wake source still wakes but sets no pending bit
// R19 - in sleep pads hold: outputs keep level, inputs stay inputs
// R20 - core power enable high normally, low in sleep
// R21 - wake needs active line, line configured as interrupt, battery_fault_n high
// R22 - after wake the line is an ordinary interrupt input again
// R23 - idle bit enters idle only after the core wrapper acknowledges
module power_mode_controller #(
    parameter logic [15:0] LOCK_RESET_CYCLES = 16'(`PMC_LOCK_CYC),
    parameter logic [15:0] WAKE_RST_CYCLES   = 16'(`PMC_WAKE_RST_CYC)
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [23:0] ext_irq_line,
    input  wire logic [15:0] extIrqConfigured,
    input  wire logic        rtcAlarm,
    input  wire logic        otherIrq,
    input  wire logic        battery_fault_n,
    input  wire logic        cpuIdleAck,
    output logic             idleReq,
    output logic             cpuClkEn,
    output logic             sysBusClkEn,
    output logic [15:0]      periphClkEn,
    output logic             pllPowerOn,
    output logic             core_power_enable,
    output logic             coreReset,
    output logic             padSleepHold
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [25:0] syncA_q;
    logic [25:0] syncB_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            syncA_q <= 26'h200_0000;
            syncB_q <= 26'h200_0000;
        end else begin
            syncA_q <= {battery_fault_n, rtcAlarm, ext_irq_line};
            syncB_q <= syncA_q;
        end
    end

    wire [23:0] extSync  = syncB_q[23:0];
    wire        rtcSync  = syncB_q[24];
    wire        battSync = syncB_q[25];

    // ----------------------------------------
    // registers
    // ----------------------------------------
    pmc_pkg::pmc_state_e state_q;
    pmc_pkg::pmc_state_e state_d;
    logic [15:0] lock_time_count_q;
    logic [31:0] cgate_q;
    logic [31:0] slowCtl_q;
    logic [1:0]  busDiv_q;
    logic        wakeFlag_q;
    logic [31:0] scratch_q;
    logic [7:0]  srcPend_q;
    logic [15:4] extPend_q;
    logic [23:0] extMask_q;
    logic        battSeen_q;
    logic [15:0] lockCnt_q;
    logic        lockDone_q;
    logic [31:0] rdData_q;
    logic        wait_q;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire        busReq    = avs_read || avs_write;
    wire        busCommit = avs_write && !wait_q;
    wire        wrLock    = busCommit && (avs_address == `PMC_ADDR_LOCK);
    wire        wrCgate   = busCommit && (avs_address == `PMC_ADDR_CGATE);
    wire        wrSlow    = busCommit && (avs_address == `PMC_ADDR_SLOW);
    wire        wrBusDiv  = busCommit && (avs_address == `PMC_ADDR_BUSDIV);
    wire        wrRstat   = busCommit && (avs_address == `PMC_ADDR_RSTAT);
    wire        wrScratch = busCommit && (avs_address == `PMC_ADDR_SCRATCH);
    wire        wrSrcPend = busCommit && (avs_address == `PMC_ADDR_SRCPEND);
    wire        wrExtPend = busCommit && (avs_address == `PMC_ADDR_EXTPEND);
    wire        wrExtMask = busCommit && (avs_address == `PMC_ADDR_EXTMASK);
    wire [31:0] wrMerged  = pmc_pkg::pmc_merge(32'h0000_0000, avs_writedata, avs_byteenable);

    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    wire slowBit    = slowCtl_q[`PMC_SC_SLOW];
    wire mpllOff    = slowCtl_q[`PMC_SC_MPLL_OFF];
    wire idleBit    = cgate_q[`PMC_CG_IDLE];
    wire sleepBit   = cgate_q[`PMC_CG_SLEEP];
    wire inSleep    = (state_q == pmc_pkg::PMC_SLEEP);
    wire divSlow    = (state_q == pmc_pkg::PMC_SLOW) || (state_q == pmc_pkg::PMC_LOCK);
    wire coreRuns   = (state_q == pmc_pkg::PMC_NORMAL) || (state_q == pmc_pkg::PMC_IDLE_REQ)
                      || divSlow;
    // R3 - idle exit sources
    wire anyIrq     = (|extSync) || rtcSync || otherIrq;
    // R11 - only lines 15..0 and alarm wake
    // R21 - configured line and battery good
    wire wakeSrc    = (|(extSync[15:0] & extIrqConfigured)) || rtcSync;
    // R22 - wake decode only while sleeping
    wire wakeGo     = inSleep && wakeSrc && battSync;
    wire idleExit   = (state_q == pmc_pkg::PMC_IDLE) && anyIrq;
    wire rstBusy;

    // ----------------------------------------
    // mode sequencer
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            pmc_pkg::PMC_NORMAL: begin
                // R12 - sleep bit ends preparation
                if (sleepBit) begin
                    state_d = pmc_pkg::PMC_SLEEP;
                end else if (idleBit) begin
                    state_d = pmc_pkg::PMC_IDLE_REQ;
                end else if (slowBit) begin
                    state_d = pmc_pkg::PMC_SLOW;
                end
            end
            pmc_pkg::PMC_IDLE_REQ: begin
                // R23 - wait for wrapper ack
                if (cpuIdleAck) begin
                    state_d = pmc_pkg::PMC_IDLE;
                end
            end
            pmc_pkg::PMC_IDLE: begin
                if (anyIrq) begin
                    state_d = pmc_pkg::PMC_NORMAL;
                end
            end
            pmc_pkg::PMC_SLOW: begin
                // R9 - lock already elapsed
                if (!slowBit && !mpllOff && lockDone_q) begin
                    state_d = pmc_pkg::PMC_NORMAL;
                // R6 - insert lock wait
                end else if (!slowBit && !mpllOff) begin
                    state_d = pmc_pkg::PMC_LOCK;
                end
            end
            pmc_pkg::PMC_LOCK: begin
                // R10 - switch after lock time
                if (lockDone_q) begin
                    state_d = pmc_pkg::PMC_NORMAL;
                end
            end
            pmc_pkg::PMC_SLEEP: begin
                if (wakeGo) begin
                    state_d = pmc_pkg::PMC_WAKE;
                end
            end
            pmc_pkg::PMC_WAKE: begin
                if (!rstBusy) begin
                    state_d = pmc_pkg::PMC_NORMAL;
                end
            end
            default: begin
                state_d = pmc_pkg::PMC_NORMAL;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= pmc_pkg::PMC_NORMAL;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------
    // pll lock timer
    // ----------------------------------------
    // R7 - count lock time after pll on
    wire [15:0] lockCnt_d  = lockCnt_q + 16'h0001;
    wire        lockReach  = (lockCnt_d >= lock_time_count_q);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lockCnt_q  <= 16'h0000;
            lockDone_q <= 1'b0;
        end else if (mpllOff || inSleep) begin
            lockCnt_q  <= 16'h0000;
            lockDone_q <= 1'b0;
        end else if (!lockDone_q) begin
            lockCnt_q  <= lockCnt_d;
            lockDone_q <= lockReach;
        end
    end

    // ----------------------------------------
    // clock enables and divider
    // ----------------------------------------
    logic coreTick;
    logic sysTick;
    logic perTick;

    // R8 - slow clock while slow lasts
    pmc_clk_div u_div (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .slowMode  (divSlow),
        .slowSel   (slowCtl_q[`PMC_SC_SEL_HI:0]),
        .sysDivSel (busDiv_q[`PMC_BD_SYS]),
        .perDivSel (busDiv_q[`PMC_BD_PER]),
        .coreTick  (coreTick),
        .sysTick   (sysTick),
        .perTick   (perTick)
    );

    // R14 - wake reset counter
    pmc_rst_cnt #(
        .CYCLES (WAKE_RST_CYCLES)
    ) u_rst (
        .sys_clk (sys_clk),
        .rst     (rst),
        .start   (wakeGo),
        .busy    (rstBusy)
    );

    // R2 - core clock stops in idle
    wire        cpuClkEn_d    = coreTick && coreRuns;
    wire        sysBusClkEn_d = sysTick && !inSleep;
    // R1 - per-peripheral gates
    wire [15:0] periphClkEn_d = {16{perTick && !inSleep}}
                                & cgate_q[`PMC_CG_GATE_HI:`PMC_CG_GATE_LO];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cpuClkEn          <= 1'b0;
            sysBusClkEn       <= 1'b0;
            periphClkEn       <= 16'h0000;
            pllPowerOn        <= 1'b1;
            core_power_enable <= 1'b1;
            coreReset         <= 1'b1;
            padSleepHold      <= 1'b0;
            idleReq           <= 1'b0;
        end else begin
            cpuClkEn          <= cpuClkEn_d;
            sysBusClkEn       <= sysBusClkEn_d;
            periphClkEn       <= periphClkEn_d;
            pllPowerOn        <= !mpllOff && !inSleep;
            // R20 - rails off in sleep
            core_power_enable <= !inSleep;
            coreReset         <= rstBusy;
            // R19 - pads hold in sleep
            padSleepHold      <= inSleep;
            idleReq           <= (state_q == pmc_pkg::PMC_IDLE_REQ);
        end
    end

    // ----------------------------------------
    // wake records
    // ----------------------------------------
    // R18 - mask blocks pending only
    wire [15:0] wakeRec  = (wakeGo ? extSync[15:0] & extIrqConfigured : 16'h0000)
                           & ~extMask_q[15:0];
    // R17 - pending split by line
    wire [7:0]  srcSet   = {wakeGo && battSeen_q, 3'h0, wakeRec[3:0]};
    wire [7:0]  srcClr   = wrSrcPend ? wrMerged[7:0] : 8'h00;
    wire [15:4] extClr   = wrExtPend ? wrMerged[15:4] : 12'h000;
    wire        rsClr    = wrRstat && wrMerged[`PMC_RS_WAKE];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            srcPend_q  <= 8'h00;
            extPend_q  <= 12'h000;
            wakeFlag_q <= 1'b0;
            battSeen_q <= 1'b0;
        end else begin
            srcPend_q  <= (srcPend_q & ~srcClr) | srcSet;
            extPend_q  <= (extPend_q & ~extClr) | wakeRec[15:4];
            // R15 - wake flag, set wins
            wakeFlag_q <= (wakeFlag_q && !rsClr) || wakeGo;
            battSeen_q <= inSleep && !wakeGo && (battSeen_q || !battSync);
        end
    end

    // ----------------------------------------
    // software registers
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lock_time_count_q <= LOCK_RESET_CYCLES;
            cgate_q    <= `PMC_CG_RESET;
            slowCtl_q  <= 32'h0000_0000;
            busDiv_q   <= 2'h0;
            scratch_q  <= 32'h0000_0000;
            extMask_q  <= 24'(`PMC_MASK_RESET);
        end else begin
            if (wrLock) begin
                lock_time_count_q <= 16'(pmc_pkg::pmc_merge({16'h0000, lock_time_count_q}, avs_writedata,
                                                     avs_byteenable));
            end
            if (wrCgate) begin
                cgate_q <= pmc_pkg::pmc_merge(cgate_q, avs_writedata, avs_byteenable)
                           & 32'h000F_FFFC;
            end else if (idleExit) begin
                cgate_q[`PMC_CG_IDLE] <= 1'b0;
            end else if (wakeGo) begin
                cgate_q[`PMC_CG_SLEEP] <= 1'b0;
            end
            if (wrSlow) begin
                slowCtl_q <= pmc_pkg::pmc_merge(slowCtl_q, avs_writedata, avs_byteenable)
                             & 32'h0000_0037;
            end
            if (wrBusDiv) begin
                busDiv_q <= avs_byteenable[0] ? avs_writedata[1:0] : busDiv_q;
            end
            // R16 - scratch kept through sleep
            if (wrScratch) begin
                scratch_q <= pmc_pkg::pmc_merge(scratch_q, avs_writedata, avs_byteenable);
            end
            if (wrExtMask) begin
                extMask_q <= 24'(pmc_pkg::pmc_merge({8'h00, extMask_q}, avs_writedata,
                                                    avs_byteenable));
            end
        end
    end

    // ----------------------------------------
    // read mux and handshake
    // ----------------------------------------
    wire [31:0] rdMux =
        (avs_address == `PMC_ADDR_LOCK)    ? {16'h0000, lock_time_count_q} :
        (avs_address == `PMC_ADDR_CGATE)   ? cgate_q :
        (avs_address == `PMC_ADDR_SLOW)    ? slowCtl_q :
        (avs_address == `PMC_ADDR_BUSDIV)  ? {30'h0000_0000, busDiv_q} :
        (avs_address == `PMC_ADDR_RSTAT)   ? {29'h0000_0000, wakeFlag_q, 2'h0} :
        (avs_address == `PMC_ADDR_SCRATCH) ? scratch_q :
        (avs_address == `PMC_ADDR_SRCPEND) ? {24'h00_0000, srcPend_q} :
        (avs_address == `PMC_ADDR_EXTPEND) ? {16'h0000, extPend_q, 4'h0} :
        (avs_address == `PMC_ADDR_EXTMASK) ? {8'h00, extMask_q} :
        (avs_address == `PMC_ADDR_MODE)    ? {28'h000_0000, lockDone_q, state_q} :
        32'h0000_0000;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wait_q   <= 1'b1;
            rdData_q <= 32'h0000_0000;
        end else begin
            wait_q   <= !(busReq && wait_q);
            rdData_q <= (avs_read && wait_q) ? rdMux : rdData_q;
        end
    end

    assign avs_waitrequest = wait_q;
    assign avs_readdata    = rdData_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_idle_core_stop: assert property ( // R2
        (state_q == pmc_pkg::PMC_IDLE) |=> !cpuClkEn)
        else $error("core clock ran in idle");
    a_idle_wake_any: assert property ( // R3
        (state_q == pmc_pkg::PMC_IDLE) && anyIrq |=> (state_q == pmc_pkg::PMC_NORMAL)
        ##0 !cgate_q[`PMC_CG_IDLE] || $past(wrCgate))
        else $error("idle did not end on interrupt");
    a_idle_needs_ack: assert property ( // R23
        (state_q == pmc_pkg::PMC_IDLE_REQ) && !cpuIdleAck |=> state_q != pmc_pkg::PMC_IDLE)
        else $error("idle entered without ack");
    a_lock_holds_slow: assert property ( // R10
        (state_q == pmc_pkg::PMC_LOCK) && !lockDone_q |=> (state_q == pmc_pkg::PMC_LOCK))
        else $error("lock wait cut short");
    a_slow_exit_fast: assert property ( // R9
        (state_q == pmc_pkg::PMC_SLOW) && !slowBit && !mpllOff && lockDone_q
        |=> (state_q == pmc_pkg::PMC_NORMAL))
        else $error("slow exit delayed after lock");
    a_sleep_power_off: assert property ( // R20
        inSleep ##1 inSleep |-> !core_power_enable && padSleepHold)
        else $error("core power on in sleep");
    a_batt_blocks_wake: assert property ( // R21
        inSleep && !battSync |=> inSleep)
        else $error("wake with battery fault");
    a_wake_reset_flag: assert property ( // R15
        wakeGo |=> (state_q == pmc_pkg::PMC_WAKE) && wakeFlag_q ##1 coreReset)
        else $error("wake did not raise reset and flag");
    a_wake_reset_len: assert property ( // R14
        $rose(rstBusy) |-> rstBusy[*8])
        else $error("wake reset too short");

endmodule // power_mode_controller

//--- pmc_cfg.svh
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define PMC_CLK_MHZ       40
`define PMC_LOCK_TIME_US  300
`define PMC_LOCK_CYC      (`PMC_LOCK_TIME_US * `PMC_CLK_MHZ)
`define PMC_WAKE_RST_CYC  65535

// ----------------------------------------
// register word offsets
// ----------------------------------------
`define PMC_ADDR_LOCK     4'h0
`define PMC_ADDR_CGATE    4'h1
`define PMC_ADDR_SLOW     4'h2
`define PMC_ADDR_BUSDIV   4'h3
`define PMC_ADDR_RSTAT    4'h4
`define PMC_ADDR_SCRATCH  4'h5
`define PMC_ADDR_SRCPEND  4'h6
`define PMC_ADDR_EXTPEND  4'h7
`define PMC_ADDR_EXTMASK  4'h8
`define PMC_ADDR_MODE     4'h9

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define PMC_CG_IDLE       2
`define PMC_CG_SLEEP      3
`define PMC_CG_GATE_LO    4
`define PMC_CG_GATE_HI    19
`define PMC_CG_RESET      32'h000F_FFF0
`define PMC_SC_SEL_HI     2
`define PMC_SC_SLOW       4
`define PMC_SC_MPLL_OFF   5
`define PMC_BD_PER        0
`define PMC_BD_SYS        1
`define PMC_RS_WAKE       2
`define PMC_SRC_BATT      7
`define PMC_MASK_RESET    32'h00FF_FFFF

`endif

//--- pmc_pkg.sv
package pmc_pkg;

    // ----------------------------------------
    // power mode states
    // ----------------------------------------
    typedef enum logic [2:0] {
        PMC_NORMAL   = 3'h0,
        PMC_IDLE_REQ = 3'h1,
        PMC_IDLE     = 3'h3,
        PMC_SLOW     = 3'h2,
        PMC_LOCK     = 3'h6,
        PMC_SLEEP    = 3'h4,
        PMC_WAKE     = 3'h5
    } pmc_state_e;

    typedef logic [31:0] pmc_word_t;

    // byte-enable merge of a bus write
    function automatic pmc_word_t pmc_merge(input pmc_word_t old,
                                            input pmc_word_t nw,
                                            input logic [3:0] be);
        pmc_word_t r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

endpackage

//--- pmc_clk_div.sv
module pmc_clk_div (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       slowMode,
    input  wire logic [2:0] slowSel,
    input  wire logic       sysDivSel,
    input  wire logic       perDivSel,
    output logic            coreTick,
    output logic            sysTick,
    output logic            perTick
);

    // ----------------------------------------
    // ratio: code 0 -> 1, code n -> 2n
    // ----------------------------------------
    function automatic logic [3:0] pmc_ratio(input logic [2:0] sel);
        return (sel == 3'h0) ? 4'h1 : {sel, 1'b0};
    endfunction

    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic       sysPh_q;
    logic       perPh_q;
    wire  [3:0] ratio = slowMode ? pmc_ratio(slowSel) : 4'h1;
    wire  [3:0] lastCnt = ratio - 4'h1;

    // R4 - slow core divide
    assign coreTick = (cnt_q == 4'h0);
    assign cnt_d    = (cnt_q >= lastCnt) ? 4'h0 : cnt_q + 4'h1;
    // R5 - bus halving options
    assign sysTick  = coreTick && (!sysDivSel || sysPh_q);
    assign perTick  = sysTick && (!perDivSel || perPh_q);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q   <= 4'h0;
            sysPh_q <= 1'b0;
            perPh_q <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            sysPh_q <= coreTick ? ~sysPh_q : sysPh_q;
            perPh_q <= sysTick ? ~perPh_q : perPh_q;
        end
    end

endmodule // pmc_clk_div

//--- pmc_rst_cnt.sv
module pmc_rst_cnt #(
    parameter logic [15:0] CYCLES = 16'hFFFF
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic start,
    output logic      busy
);

    logic [15:0] cnt_q;

    // R14 - counted wake reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 16'h0000;
            busy  <= 1'b0;
        end else if (start) begin
            cnt_q <= CYCLES - 16'h0001;
            busy  <= 1'b1;
        end else if (busy) begin
            cnt_q <= cnt_q - 16'h0001;
            busy  <= (cnt_q != 16'h0000);
        end
    end

endmodule // pmc_rst_cnt

//--- pmc_wake_model.sv
// ----------------------------------------
// regulator and wake source model
// ----------------------------------------
module pmc_wake_model (
    input  wire logic       sys_clk,
    input  wire logic       core_power_enable,
    input  wire logic [4:0] wakeIdx,
    input  wire logic       wakeFire,
    input  wire logic       battFault,
    output logic [23:0]     ext_irq_line,
    output logic            rtcAlarm,
    output logic            battery_fault_n,
    output logic            railOn
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ext_irq_line = '0;
        rtcAlarm = 1'b0;
        battery_fault_n = 1'b1;
        railOn = 1'b1;
    end
    always @(posedge sys_clk) railOn <= core_power_enable;
    always @(posedge sys_clk) battery_fault_n <= !battFault;
    always @(posedge sys_clk) begin
        if (wakeFire && !railOn) begin
            ext_irq_line <= 24'h00_0003 << wakeIdx;
        end else if (railOn) begin
            ext_irq_line <= '0;
        end
    end
endmodule // pmc_wake_model

//--- testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst = 1, avs_read = 0, avs_write = 0;
    logic [3:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, rdata;
    logic avs_waitrequest, cpuIdleAck = 0, otherIrq = 0, wakeFire = 0, battFault = 0;
    logic [4:0] wakeIdx = 5'd5;
    logic [23:0] extLine;
    logic rtcAlarm, battery_fault_n, cpuClkEn, core_power_enable, padSleepHold;
    logic idleReq, sysBusClkEn, pllPowerOn, coreReset;
    logic [15:0] periphClkEn;
    int errors = 0, comparisons = 0, cyc = 0, n;
    always #12.5 sys_clk = ~sys_clk;
    pmc_wake_model part (.sys_clk(sys_clk), .core_power_enable(core_power_enable),
        .wakeIdx(wakeIdx), .wakeFire(wakeFire), .battFault(battFault), .ext_irq_line(extLine),
        .rtcAlarm(rtcAlarm), .battery_fault_n(battery_fault_n), .railOn());
    power_mode_controller #(.LOCK_RESET_CYCLES(16'h0014), .WAKE_RST_CYCLES(16'h000A)) dut (
        .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ext_irq_line(extLine), .extIrqConfigured(16'hFFFF), .rtcAlarm(rtcAlarm),
        .otherIrq(otherIrq), .battery_fault_n(battery_fault_n), .cpuIdleAck(cpuIdleAck),
        .idleReq(idleReq), .cpuClkEn(cpuClkEn), .sysBusClkEn(sysBusClkEn),
        .periphClkEn(periphClkEn), .pllPowerOn(pllPowerOn),
        .core_power_enable(core_power_enable), .coreReset(coreReset),
        .padSleepHold(padSleepHold));
    // ----------------------------------------
    // bus tasks and checks
    // ----------------------------------------
    task automatic acc(input logic [3:0] a, input logic w, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_write <= 0;
        avs_read <= 0;
        @(posedge sys_clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
        acc(a, 0, '0);
        chk(rdata, exp);
    endtask
    task automatic waitState(input logic [2:0] s);
        n = 0;
        do begin acc(4'h9, 0, '0); n++; end while (rdata[2:0] !== s && n < 200);
        chk({29'h0, rdata[2:0]}, {29'h0, s});
    endtask
    task automatic ticks(input int exp);
        n = 0;
        repeat (8) begin @(posedge sys_clk); n += int'(cpuClkEn === 1'b1); end
        chk(n, exp);
    endtask
    task automatic stop_test;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 6000) begin errors++; stop_test; end
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 0;
        @(posedge sys_clk);
        rdchk(4'h1, 32'h000F_FFF0);
        chk(periphClkEn, 16'hFFFF);
        rdchk(4'hA, 32'h0000_0000);
        acc(4'h0, 1, 32'h0000_0014);
        acc(4'h2, 1, 32'h0000_0011);
        waitState(3'h2);
        ticks(4);
        acc(4'h2, 1, 32'h0000_0031);
        @(posedge sys_clk);
        chk(pllPowerOn, 1'b0);
        acc(4'h2, 1, 32'h0000_0000);
        rdchk(4'h9, 32'h0000_0006);
        waitState(3'h0);
        $display("test slow done");
        acc(4'h1, 1, 32'h0000_FFF4);
        rdchk(4'h9, 32'h0000_0009);
        chk(idleReq, 1'b1);
        cpuIdleAck <= 1;
        waitState(3'h3);
        ticks(0);
        chk(sysBusClkEn, 1'b1);
        chk(periphClkEn, 16'h0FFF);
        otherIrq <= 1;
        waitState(3'h0);
        otherIrq <= 0;
        $display("test idle done");
        acc(4'h5, 1, 32'h0000_0018);
        acc(4'h8, 1, 32'h0000_0040);
        acc(4'h1, 1, 32'h000F_FFF8);
        repeat (4) @(posedge sys_clk);
        chk(core_power_enable, 1'b0);
        chk(padSleepHold, 1'b1);
        wakeFire <= 1;
        battFault <= 1;
        repeat (8) @(posedge sys_clk);
        chk(core_power_enable, 1'b0);
        battFault <= 0;
        n = 0;
        while (core_power_enable !== 1'b1 && n < 300) begin @(posedge sys_clk); n++; end
        wakeFire <= 0;
        chk(core_power_enable, 1'b1);
        chk(coreReset, 1'b1);
        waitState(3'h0);
        rdchk(4'h4, 32'h0000_0004);
        rdchk(4'h5, 32'h0000_0018);
        rdchk(4'h7, 32'h0000_0020);
        rdchk(4'h6, 32'h0000_0080);
        acc(4'h4, 1, 32'h0000_0004);
        rdchk(4'h4, 32'h0000_0000);
        $display("test sleep done");
        stop_test;
    end
endmodule // testbench
